// [bem_pkg.sv]
package bem_pkg;

  // ----------------------------------------------------------------
  // event select codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EV_NOT_READY  = 8'h61;
  localparam logic [7:0] EV_DATA_VALID = 8'h62;
  localparam logic [7:0] EV_LOCK       = 8'h63;
  localparam logic [7:0] EV_RECEIVE    = 8'h64;
  localparam logic [7:0] EV_BURST_RD   = 8'h65;
  localparam logic [7:0] EV_OWN_RD     = 8'h66;
  localparam logic [7:0] EV_WRITEBACK  = 8'h67;
  localparam logic [7:0] EV_IFETCH     = 8'h68;
  localparam logic [7:0] EV_INVALIDATE = 8'h69;

  // ----------------------------------------------------------------
  // transaction kinds seen on the request phase
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BEM_TX_BURST_RD = 3'h0,
    BEM_TX_OWN_RD   = 3'h1,
    BEM_TX_WB_EXPL  = 3'h2,
    BEM_TX_WB_IMPL  = 3'h3,
    BEM_TX_PARTIAL  = 3'h4,
    BEM_TX_INVAL    = 3'h5,
    BEM_TX_OTHER    = 3'h6
  } bem_txn_t;

  // ----------------------------------------------------------------
  // burst read sources
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BEM_SRC_L1D    = 2'h0,
    BEM_SRC_L2PF   = 2'h1,
    BEM_SRC_IFETCH = 2'h2,
    BEM_SRC_NONE   = 2'h3
  } bem_src_t;

  localparam logic [7:0] UMASK_ANY = 8'h00;

endpackage

// [bem_bus_event_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// - code 61h counts cycles where this processor drives bus-not-ready
// - not-ready is driven when outstanding transactions near bus limit
// - while not-ready stands, no new transaction is issued
// - code 62h increments each cycle data-valid strobe is asserted
// - 62h covers all writes: explicit, implicit writebacks, partial
// - code 63h increments each cycle bus lock is asserted
// - lock used for uncacheable, split-line, uncacheable page walk
// - code 64h increments each cycle processor receives data
// - events 61h to 64h ignore thread qualifier; one shared count
// - 65h counts burst reads from l1d, l2 prefetch, fetch misses
// - burst read count excludes read-for-ownership transactions
// - 66h counts ownership reads from stores missing l1d and l2
// - 66h also counts ownership reads from locked operations
// - 67h counts explicit writebacks from dirty line evictions
// - 67h excludes implicit writebacks caused by snoops
// - 68h counts full-line instruction fetch transactions
// - 69h counts invalidates; store hitting shared l2 line issues one
// - full-line write missing l2 or hitting shared also invalidates
module bem_bus_event_monitor
  import bem_pkg::*;
#(
  parameter int OUTST_W     = 4,
  parameter int OUTST_LIMIT = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // event selection
  input  wire logic [7:0]   event_select,
  input  wire logic [7:0]   unit_mask,
  input  wire logic [7:0]   unit_mask_expect,
  input  wire logic         any_thread_qualifier,
  // bus pins seen by the monitor (asynchronous to logic)
  input  wire logic         data_valid_strobe_pin,
  input  wire logic         bus_lock_pin,
  input  wire logic         receive_busy_pin,
  input  wire logic         bus_not_ready_in_pin,
  // core transaction request side
  input  wire logic         txn_req,
  input  wire bem_txn_t     txn_kind,
  input  wire bem_src_t     txn_src,
  input  wire logic         txn_cacheable,
  input  wire logic         txn_full_line,
  input  wire logic         txn_locked,
  input  wire logic         txn_done,
  output logic              txn_ready,
  // bus not-ready drive (open drain)
  output logic              bus_not_ready_o,
  output logic              bus_not_ready_oe,
  // counter increment
  output logic              count_inc
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q, sync2_q;
  logic [3:0] sync1_d;

  always_comb begin
    sync1_d = {bus_not_ready_in_pin, receive_busy_pin, bus_lock_pin,
               data_valid_strobe_pin};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync1_q;
    end
  end

  logic dv_s, lock_s, rcv_s, bnr_other_s;
  assign dv_s        = sync2_q[0];
  assign lock_s      = sync2_q[1];
  assign rcv_s       = sync2_q[2];
  assign bnr_other_s = sync2_q[3];

  // ----------------------------------------------------------------
  // outstanding tracking and not-ready drive
  // ----------------------------------------------------------------
  logic [OUTST_W-1:0] outst_q, outst_d;
  logic               bnr_q, bnr_d;
  logic               issue;

  // new requests held while anyone drives not-ready
  assign txn_ready = !bnr_q && !bnr_other_s;
  assign issue     = txn_req && txn_ready;

  always_comb begin
    outst_d = outst_q;
    if (issue && !txn_done)
      outst_d = outst_q + OUTST_W'(1);
    else if (!issue && txn_done && outst_q != '0)
      outst_d = outst_q - OUTST_W'(1);
    // assert one short of the limit so in-flight issue still fits
    bnr_d = (outst_d >= OUTST_W'(OUTST_LIMIT - 1));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outst_q <= '0;
      bnr_q   <= 1'b0;
    end else begin
      outst_q <= outst_d;
      bnr_q   <= bnr_d;
    end
  end

  assign bus_not_ready_o  = 1'b0;
  assign bus_not_ready_oe = bnr_q;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  function automatic logic sel(input logic [7:0] code);
    sel = (event_select == code);
  endfunction

  logic mask_ok;
  logic cyc_hit, txn_hit;
  logic inc_d, inc_q;

  // unit mask must match; thread qualifier does not split counts
  assign mask_ok = (unit_mask == unit_mask_expect);

  always_comb begin
    cyc_hit = 1'b0;
    txn_hit = 1'b0;
    if (sel(EV_NOT_READY))  cyc_hit = bnr_q;
    if (sel(EV_DATA_VALID)) cyc_hit = dv_s;
    if (sel(EV_LOCK))       cyc_hit = lock_s;
    if (sel(EV_RECEIVE))    cyc_hit = rcv_s;
    if (issue) begin
      if (sel(EV_BURST_RD))
        txn_hit = (txn_kind == BEM_TX_BURST_RD) &&
                  (txn_src != BEM_SRC_NONE) &&
                  (txn_src != BEM_SRC_IFETCH || txn_cacheable);
      if (sel(EV_OWN_RD))
        txn_hit = (txn_kind == BEM_TX_OWN_RD);
      if (sel(EV_WRITEBACK))
        txn_hit = (txn_kind == BEM_TX_WB_EXPL);
      if (sel(EV_IFETCH))
        txn_hit = (txn_src == BEM_SRC_IFETCH) && txn_full_line;
      if (sel(EV_INVALIDATE))
        txn_hit = (txn_kind == BEM_TX_INVAL);
    end
    inc_d = mask_ok && (cyc_hit || txn_hit);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      inc_q <= 1'b0;
    else
      inc_q <= inc_d;
  end

  assign count_inc = inc_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_bnr_count: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_NOT_READY) && mask_ok && bnr_q) |=> count_inc)
    else $error("not-ready cycle not counted");

  chk_hold_issue: assert property (@(posedge clk) disable iff (!rst_n)
    bnr_q |-> !txn_ready)
    else $error("request accepted during not-ready");

  chk_bnr_limit: assert property (@(posedge clk) disable iff (!rst_n)
    (outst_q >= OUTST_W'(OUTST_LIMIT - 1)) |-> bnr_q)
    else $error("not-ready missing near limit");

  chk_dv_count: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_DATA_VALID) && mask_ok && dv_s) |=> count_inc)
    else $error("data-valid cycle not counted");

  chk_lock_cnt: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_LOCK) && mask_ok && $rose(lock_s)) |=> count_inc)
    else $error("lock cycle not counted");

  chk_rcv_count: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_RECEIVE) && mask_ok && !rcv_s) |=> !count_inc)
    else $error("receive count without busy");

  chk_no_rfo_brd: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_BURST_RD) && issue && txn_kind == BEM_TX_OWN_RD) |=> !count_inc)
    else $error("ownership read counted as burst");

  chk_no_impl_wb: assert property (@(posedge clk) disable iff (!rst_n)
    (sel(EV_WRITEBACK) && issue && txn_kind == BEM_TX_WB_IMPL) |=> !count_inc)
    else $error("implicit writeback counted");

  chk_mask_gate: assert property (@(posedge clk) disable iff (!rst_n)
    !mask_ok |=> !count_inc)
    else $error("count with mismatched mask");

endmodule
`default_nettype wire

// [bem_agent_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bem_agent_model (
  // clock, reset and control
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic active,
  input  wire logic hold_off,
  input  wire logic proc_not_ready,
  // bus pins
  output logic      data_valid,
  output logic      lock,
  output logic      receive,
  output logic      not_ready
);
  // ------------------------------------------------------------
  // other agents
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {data_valid, lock, receive, not_ready} <= 4'h0;
    end else begin
      data_valid <= #1 active && $urandom_range(1);
      // never start a new locked access while the processor drives not-ready
      lock       <= #1 active && !proc_not_ready && $urandom_range(1);
      receive    <= #1 active && $urandom_range(1);
      not_ready  <= #1 hold_off;
    end
  end
endmodule
`default_nettype wire

// [bem_bus_event_monitor_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module bem_bus_event_monitor_bench;
  import bem_pkg::*;
  // ------------------------------------------------------------
  // stimulus and scoreboard
  // ------------------------------------------------------------
  logic       clk = 0, rst_n = 0, act = 0, hold = 0, req = 0, done = 0;
  logic       aq = 0, cach = 0, full = 0, lk = 0;
  logic [7:0] sel = 0, um = 0, ume = 0;
  logic [7:0] pins [4] = '{EV_DATA_VALID, EV_LOCK, EV_RECEIVE, EV_DATA_VALID};
  bem_txn_t   kind = BEM_TX_OTHER;
  bem_src_t   src = BEM_SRC_NONE;
  logic       dv, lock, rcv, nr, rdy, nro, oe, inc;
  int         cyc = 0, mismatches = 0, n_compared = 0;
  int         q[$];
  always #4 clk = ~clk;
  bem_bus_event_monitor DUT (.clk(clk), .rst_n(rst_n), .event_select(sel),
    .unit_mask(um), .unit_mask_expect(ume), .any_thread_qualifier(aq),
    .data_valid_strobe_pin(dv), .bus_lock_pin(lock), .receive_busy_pin(rcv),
    .bus_not_ready_in_pin(nr), .txn_req(req), .txn_kind(kind),
    .txn_src(src), .txn_cacheable(cach), .txn_full_line(full),
    .txn_locked(lk), .txn_done(done), .txn_ready(rdy),
    .bus_not_ready_o(nro), .bus_not_ready_oe(oe), .count_inc(inc));
  bem_agent_model agents (.clk(clk), .rst_n(rst_n), .active(act),
    .hold_off(hold), .proc_not_ready(oe), .data_valid(dv), .lock(lock),
    .receive(rcv), .not_ready(nr));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic hit(bem_txn_t k, bem_src_t s);
    case (sel)
      EV_BURST_RD:   return k == BEM_TX_BURST_RD && s != BEM_SRC_NONE &&
                            (s != BEM_SRC_IFETCH || cach);
      EV_OWN_RD:     return k == BEM_TX_OWN_RD;
      EV_WRITEBACK:  return k == BEM_TX_WB_EXPL;
      EV_IFETCH:     return full && s == BEM_SRC_IFETCH;
      EV_INVALIDATE: return k == BEM_TX_INVAL;
      default:       return 1'b0;
    endcase
  endfunction
  task automatic issue(bem_txn_t k, bem_src_t s);
    tick(1);
    req = 1; kind = k; src = s; lk = $urandom_range(1);
    cach = $urandom_range(1); full = $urandom_range(1);
    check("ready", rdy, 1);
    if (ume == um && hit(k, s)) q.push_back(cyc + 1);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  // pin events land three cycles late: two input synchroniser stages plus the count register
  always @(negedge clk) if (rst_n) begin
    if (ume == um && sel == EV_NOT_READY && oe) q.push_back(cyc + 1);
    if (ume == um && sel == EV_DATA_VALID && dv) q.push_back(cyc + 3);
    if (ume == um && sel == EV_LOCK && lock) q.push_back(cyc + 3);
    if (ume == um && sel == EV_RECEIVE && rcv) q.push_back(cyc + 3);
    if (inc !== 1'b0) check("increment", cyc, q.size() ? q.pop_front() : -1);
  end
  initial begin
    void'($urandom(53612));
    tick(5);
    rst_n = 1;
    um = $urandom_range(255);
    ume = um;
    for (int e = 8'h65; e <= 8'h69; e++) begin
      sel = e[7:0];
      repeat (50) begin
        aq = $urandom_range(1);
        issue(bem_txn_t'($urandom_range(6)), bem_src_t'($urandom_range(3)));
        tick(1);
        req = 0; done = 1;
        tick(1);
        done = 0;
        ume = ($urandom_range(7) == 0) ? ~um : um;
      end
    end
    sel = EV_NOT_READY; ume = um;
    repeat (7) issue(BEM_TX_OWN_RD, BEM_SRC_L1D);
    tick(1);
    req = 0;
    tick(2);
    check("not ready driven", oe, 1);
    check("open drain level", nro, 0);
    req = 1;
    tick(2);
    check("refused", rdy, 0);
    done = 1;
    tick(1);
    done = 0;
    for (int i = 0; i < 8 && rdy !== 1'b1; i++) tick(1);
    check("released", rdy, 1);
    tick(1);
    req = 0;
    repeat (7) begin done = 1; tick(1); done = 0; tick(1); end
    hold = 1;
    tick(4);
    check("held off", rdy, 0);
    hold = 0;
    tick(4);
    check("resumed", rdy, 1);
    for (int i = 0; i < 4; i++) begin
      sel = pins[i];
      ume = (i == 3) ? ~um : um;
      tick(2);
      act = 1;
      tick(40);
      act = 0;
      tick(6);
    end
    check("pending increments", q.size(), 0);
    wrap_up();
  end
endmodule
`default_nettype wire
